/* rtl/smsp_edge.sv */
/*
 * smsp_edge: registers the serial clock and select inputs once and flags
 * their edges for the slave shifter.
 * Assumes pins already synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module smsp_edge (
    input  wire logic clk_i,       // bus clock
    input  wire logic reset_n_i,   // sync reset, active low
    input  wire logic sck_i,       // serial clock pin level
    input  wire logic sel_n_i,     // select pin level
    output logic      sck_rise_o,  // rising edge seen
    output logic      sck_fall_o,  // falling edge seen
    output logic      sel_fall_o   // select went low
);
    logic sck_q, sel_q;
    logic next_sck_q, next_sel_q;

    // previous levels; reset to idle so enable does not fake an edge
    always_comb begin
        next_sck_q = sck_i;
        next_sel_q = sel_n_i;
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sck_q <= 1'b0;
            sel_q <= 1'b1;
        end else begin
            sck_q <= next_sck_q;
            sel_q <= next_sel_q;
        end
    end

    assign sck_rise_o = sck_i & ~sck_q;
    assign sck_fall_o = ~sck_i & sck_q;
    assign sel_fall_o = ~sel_n_i & sel_q;
endmodule : smsp_edge // smsp_edge
`default_nettype wire

/* rtl/smsp_pkg.sv */
/*
 * smsp_pkg: register map, field positions, reset values and rate counts
 * for the serial master/slave port.
 * Assumes a 32-bit AXI4-Lite register bus, one byte register per word.
 */
package smsp_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [15:0] SMSP_IDX_CONTROL = 16'h0010;
    localparam logic [15:0] SMSP_IDX_STATUS  = 16'h0011;
    localparam logic [15:0] SMSP_IDX_DATA    = 16'h0012;
    localparam logic [7:0]  SMSP_ADDR_CONTROL = 8'h40;
    localparam logic [7:0]  SMSP_ADDR_STATUS  = 8'h44;
    localparam logic [7:0]  SMSP_ADDR_DATA    = 8'h48;

    // control register fields
    localparam int SMSP_CTL_RX_IRQ_EN = 7;
    localparam int SMSP_CTL_MASTER    = 5;
    localparam int SMSP_CTL_CLOCK_POLARITY      = 4;
    localparam int SMSP_CTL_CLOCK_PHASE      = 3;
    localparam int SMSP_CTL_WIRED_OR  = 2;
    localparam int SMSP_CTL_ENABLE    = 1;
    localparam int SMSP_CTL_TX_IRQ_EN = 0;
    localparam logic [7:0] SMSP_CTL_RESET = 8'h28;

    // status/control register fields
    localparam int SMSP_ST_RX_FULL  = 7;
    localparam int SMSP_ST_ERR_IE   = 6;
    localparam int SMSP_ST_OVERRUN  = 5;
    localparam int SMSP_ST_ROLE_FLT = 4;
    localparam int SMSP_ST_TX_EMPTY = 3;
    localparam int SMSP_ST_FAULT_EN = 2;
    localparam logic [7:0] SMSP_ST_RESET = 8'h08;
    localparam logic [7:0] SMSP_ST_WMASK = 8'h47;

    // half bit time in bus cycles for rate settings 0..3 (2, 8, 32, 128 per bit)
    localparam logic [6:0] SMSP_HALF_DIV2   = 7'h01;
    localparam logic [6:0] SMSP_HALF_DIV8   = 7'h04;
    localparam logic [6:0] SMSP_HALF_DIV32  = 7'h10;
    localparam logic [6:0] SMSP_HALF_DIV128 = 7'h40;

    localparam logic [1:0] SMSP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SMSP_RESP_SLVERR = 2'h2;
endpackage : smsp_pkg

/* rtl/smsp_port.sv */
/*
 * smsp_port: full-duplex serial port, master or slave, with control,
 * status/control and data registers on an AXI4-Lite slave.
 * Assumes link pins synchronous to clk_i; pin muxing lies outside.
 */
`timescale 1ns/1ps
`default_nettype none
module smsp_port
    import smsp_pkg::*;
(
    input  wire logic        clk_i,          // bus clock, 100 MHz
    input  wire logic        reset_n_i,      // sync reset, active low
    input  wire logic [7:0]  s_axi_awaddr,   // write address
    input  wire logic        s_axi_awvalid,  // write address valid
    output logic             s_axi_awready,  // write address ready
    input  wire logic [31:0] s_axi_wdata,    // write data
    input  wire logic [3:0]  s_axi_wstrb,    // write strobes
    input  wire logic        s_axi_wvalid,   // write data valid
    output logic             s_axi_wready,   // write data ready
    output logic [1:0]       s_axi_bresp,    // write response
    output logic             s_axi_bvalid,   // write response valid
    input  wire logic        s_axi_bready,   // write response ready
    input  wire logic [7:0]  s_axi_araddr,   // read address
    input  wire logic        s_axi_arvalid,  // read address valid
    output logic             s_axi_arready,  // read address ready
    output logic [31:0]      s_axi_rdata,    // read data
    output logic [1:0]       s_axi_rresp,    // read response
    output logic             s_axi_rvalid,   // read data valid
    input  wire logic        s_axi_rready,   // read data ready
    input  wire logic        sclk_i,         // serial clock pin in
    output logic             sclk_o,         // serial clock pin out
    output logic             sclk_oe_o,      // serial clock drive enable
    input  wire logic        mosi_i,         // master-out line in
    output logic             mosi_o,         // master-out line out
    output logic             mosi_oe_o,      // master-out drive enable
    input  wire logic        miso_i,         // master-in line in
    output logic             miso_o,         // master-in line out
    output logic             miso_oe_o,      // master-in drive enable
    input  wire logic        select_n_i      // slave select, active low
);
    typedef enum logic [1:0] {SMSP_IDLE, SMSP_LEAD, SMSP_SHIFT} smsp_state_type;

    // registers
    logic [7:0] ctl, stat, rx_data, tx_buf, shreg;
    logic       tx_full, status_seen;
    logic [6:0] div_cnt;
    logic [3:0] half_cnt;
    logic       sck_lvl, rx_bit;
    smsp_state_type state;
    logic [7:0] next_ctl, next_stat, next_rx_data, next_tx_buf, next_shreg;
    logic       next_tx_full, next_status_seen;
    logic [6:0] next_div_cnt;
    logic [3:0] next_half_cnt;
    logic       next_sck_lvl, next_rx_bit;
    smsp_state_type next_state;

    // bus slave state
    logic       aw_hold, w_hold, bvalid, rvalid;
    logic [7:0] aw_addr, ar_data;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] bresp, rresp;
    logic       next_aw_hold, next_w_hold, next_bvalid, next_rvalid;
    logic [7:0] next_aw_addr, next_ar_data;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic [1:0] next_bresp, next_rresp;

    logic sck_rise, sck_fall, sel_fall;
    logic wr_go, rd_go, wr_ctl, wr_stat, wr_data, rd_stat, rd_data;
    logic enabled, is_master, clock_phase, clock_polarity, slave_sel;
    logic rx_capture, tx_load;

    // true for the three mapped word addresses
    function automatic logic smsp_mapped(input logic [7:0] a);
        smsp_mapped = (a == SMSP_ADDR_CONTROL) || (a == SMSP_ADDR_STATUS) ||
                      (a == SMSP_ADDR_DATA);
    endfunction

    smsp_edge u_edge (
        .clk_i      (clk_i),
        .reset_n_i  (reset_n_i),
        .sck_i      (sclk_i),
        .sel_n_i    (select_n_i),
        .sck_rise_o (sck_rise),
        .sck_fall_o (sck_fall),
        .sel_fall_o (sel_fall)
    );

    assign enabled   = ctl[SMSP_CTL_ENABLE];
    assign is_master = ctl[SMSP_CTL_MASTER];
    assign clock_phase      = ctl[SMSP_CTL_CLOCK_PHASE];
    assign clock_polarity      = ctl[SMSP_CTL_CLOCK_POLARITY];
    assign slave_sel = enabled && !is_master && !select_n_i;

    // bus handshakes; address and data taken in either order
    assign s_axi_awready = !aw_hold && !bvalid;
    assign s_axi_wready  = !w_hold && !bvalid;
    assign s_axi_arready = !rvalid;
    assign wr_go = aw_hold && w_hold && !bvalid;
    assign rd_go = s_axi_arvalid && !rvalid;
    assign wr_ctl  = wr_go && w_strb[0] && (aw_addr == SMSP_ADDR_CONTROL);
    assign wr_stat = wr_go && w_strb[0] && (aw_addr == SMSP_ADDR_STATUS);
    assign wr_data = wr_go && w_strb[0] && (aw_addr == SMSP_ADDR_DATA);
    assign rd_stat = rd_go && (s_axi_araddr == SMSP_ADDR_STATUS);
    assign rd_data = rd_go && (s_axi_araddr == SMSP_ADDR_DATA);

    always_comb begin
        next_aw_hold = aw_hold;
        next_w_hold  = w_hold;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rresp   = rresp;
        next_ar_data = ar_data;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_hold = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_hold = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            next_aw_hold = 1'b0;
            next_w_hold  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = smsp_mapped(aw_addr) ? SMSP_RESP_OKAY : SMSP_RESP_SLVERR;
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (rd_go) begin
            next_rvalid = 1'b1;
            next_rresp  = smsp_mapped(s_axi_araddr) ? SMSP_RESP_OKAY : SMSP_RESP_SLVERR;
            if (s_axi_araddr == SMSP_ADDR_CONTROL) begin
                next_ar_data = ctl;
            end else if (s_axi_araddr == SMSP_ADDR_STATUS) begin
                next_ar_data = stat;
            end else if (s_axi_araddr == SMSP_ADDR_DATA) begin
                next_ar_data = rx_data;
            end else begin
                next_ar_data = 8'h00;
            end
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= SMSP_RESP_OKAY;
            rvalid  <= 1'b0;
            rresp   <= SMSP_RESP_OKAY;
            ar_data <= 8'h00;
        end else begin
            aw_hold <= next_aw_hold;
            w_hold  <= next_w_hold;
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rresp   <= next_rresp;
            ar_data <= next_ar_data;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp  = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp  = rresp;
    assign s_axi_rdata  = {24'h00_0000, ar_data};

    // shift engine: master divider, slave edge follower, buffers and flags
    always_comb begin
        logic [6:0] half;
        logic       lead_edge, trail_edge, start, done;
        half = SMSP_HALF_DIV2;
        lead_edge = 1'b0;
        trail_edge = 1'b0;
        start = 1'b0;
        done = 1'b0;
        next_ctl = ctl;
        next_stat = stat;
        next_rx_data = rx_data;
        next_tx_buf = tx_buf;
        next_shreg = shreg;
        next_tx_full = tx_full;
        next_status_seen = status_seen;
        next_div_cnt = div_cnt;
        next_half_cnt = half_cnt;
        next_sck_lvl = sck_lvl;
        next_rx_bit = rx_bit;
        next_state = state;
        rx_capture = 1'b0;
        tx_load = 1'b0;
        case (stat[1:0])
            2'h0: half = SMSP_HALF_DIV2;
            2'h1: half = SMSP_HALF_DIV8;
            2'h2: half = SMSP_HALF_DIV32;
            default: half = SMSP_HALF_DIV128;
        endcase
        if (wr_ctl) begin
            next_ctl = w_data[7:0] & 8'hbf;
        end
        if (wr_stat) begin
            next_stat = (stat & ~SMSP_ST_WMASK) | (w_data[7:0] & SMSP_ST_WMASK);
        end
        // status read arms the clear; data read completes it
        if (rd_stat && stat[SMSP_ST_RX_FULL]) begin
            next_status_seen = 1'b1;
        end
        if (rd_data && status_seen) begin
            next_stat[SMSP_ST_RX_FULL] = 1'b0;
            next_stat[SMSP_ST_OVERRUN] = 1'b0;
            next_status_seen = 1'b0;
        end
        if (wr_data) begin
            next_tx_buf = w_data[7:0];
            next_tx_full = 1'b1;
            next_stat[SMSP_ST_TX_EMPTY] = 1'b0;
            next_ctl[SMSP_CTL_TX_IRQ_EN] = 1'b0;
        end
        // master contention: select low while mastering
        if (enabled && is_master && !select_n_i && stat[SMSP_ST_FAULT_EN]) begin
            next_stat[SMSP_ST_ROLE_FLT] = 1'b1;
        end
        // edge sources: master from divider, slave from pins
        if (is_master) begin
            if (state == SMSP_IDLE) begin
                next_div_cnt = 7'h00;
            end else if (div_cnt + 7'h01 >= half) begin
                next_div_cnt = 7'h00;
                if (state == SMSP_LEAD) begin
                    next_state = SMSP_SHIFT;
                    if (clock_phase) begin
                        lead_edge = 1'b1;
                    end
                end else if (sck_lvl == clock_polarity) begin
                    lead_edge = 1'b1;
                end else begin
                    trail_edge = 1'b1;
                end
            end else begin
                next_div_cnt = div_cnt + 7'h01;
            end
        end else if (slave_sel) begin
            // edges counted at bus rate, independent of rate bits
            lead_edge  = clock_polarity ? sck_fall : sck_rise;
            trail_edge = clock_polarity ? sck_rise : sck_fall;
        end
        if (state == SMSP_IDLE) begin
            // follow a polarity write at once; the idle level lags only a write made in the done cycle
            next_sck_lvl = next_ctl[SMSP_CTL_CLOCK_POLARITY];
            next_half_cnt = 4'h0;
            if (enabled && is_master && tx_full) begin
                start = 1'b1;
                next_state = SMSP_LEAD;
            end else if (slave_sel && (clock_phase ? lead_edge : sel_fall)) begin
                start = 1'b1;
                next_state = SMSP_SHIFT;
            end
            if (start && tx_full) begin
                tx_load = 1'b1;
            end
            if (start && !is_master && clock_phase) begin
                next_half_cnt = 4'h1;                                  // first edge counted
            end
        end else begin
            if (lead_edge || trail_edge) begin
                next_half_cnt = half_cnt + 4'h1;
                if (is_master) begin
                    next_sck_lvl = ~sck_lvl;
                end
            end
            // phase 0 samples on leading edge, phase 1 on trailing; the out
            // line moves on the other edge, bar the first phase 1 edge, so the far side sees it settled
            if ((clock_phase ? trail_edge : lead_edge)) begin
                next_rx_bit = is_master ? miso_i : mosi_i;
                if (half_cnt[3:1] == 3'h1 && stat[SMSP_ST_RX_FULL]) begin
                    next_stat[SMSP_ST_OVERRUN] = 1'b1;
                end
            end
            if (clock_phase ? (lead_edge && half_cnt != 4'h0) : trail_edge) begin
                next_shreg = {shreg[6:0], rx_bit};
            end
            if ((lead_edge || trail_edge) && half_cnt == 4'hf) begin
                done = 1'b1;
                if (clock_phase) begin
                    next_shreg = {shreg[6:0], next_rx_bit};             // no shift edge follows
                end
            end
            if (!is_master && !slave_sel) begin
                next_state = SMSP_IDLE;
            end
        end
        if (done) begin
            next_state = SMSP_IDLE;
            next_sck_lvl = clock_polarity;
            if (!stat[SMSP_ST_OVERRUN] && !next_stat[SMSP_ST_OVERRUN]) begin
                rx_capture = 1'b1;
                next_rx_data = next_shreg;
                next_stat[SMSP_ST_RX_FULL] = 1'b1;
            end
        end
        if (tx_load) begin
            next_shreg = tx_buf;
            next_tx_full = wr_data;
            next_stat[SMSP_ST_TX_EMPTY] = !wr_data;
        end
        if (!enabled) begin
            next_state = SMSP_IDLE;
            next_sck_lvl = next_ctl[SMSP_CTL_CLOCK_POLARITY];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ctl <= SMSP_CTL_RESET;
            stat <= SMSP_ST_RESET;
            rx_data <= 8'h00;
            tx_buf <= 8'h00;
            shreg <= 8'h00;
            tx_full <= 1'b0;
            status_seen <= 1'b0;
            div_cnt <= 7'h00;
            half_cnt <= 4'h0;
            sck_lvl <= 1'b0;
            rx_bit <= 1'b0;
            state <= SMSP_IDLE;
        end else begin
            ctl <= next_ctl;
            stat <= next_stat;
            rx_data <= next_rx_data;
            tx_buf <= next_tx_buf;
            shreg <= next_shreg;
            tx_full <= next_tx_full;
            status_seen <= next_status_seen;
            div_cnt <= next_div_cnt;
            half_cnt <= next_half_cnt;
            sck_lvl <= next_sck_lvl;
            rx_bit <= next_rx_bit;
            state <= next_state;
        end
    end

    // pin drive: master drives clock and out line; selected slave drives in line
    assign sclk_o    = sck_lvl;
    assign sclk_oe_o = enabled && is_master;
    assign mosi_o    = shreg[7];
    assign mosi_oe_o = enabled && is_master;
    assign miso_o    = shreg[7];
    assign miso_oe_o = slave_sel;
    a_rx_clear_seq: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (stat[SMSP_ST_RX_FULL] && !status_seen && !rx_capture)
        |=> stat[SMSP_ST_RX_FULL])
        else $error("receive full cleared without status read");
    a_capture_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rx_capture |=> stat[SMSP_ST_RX_FULL] && rx_data == $past(next_rx_data))
        else $error("capture did not set full with data");
    a_slave_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        select_n_i |-> !miso_oe_o)
        else $error("unselected slave drives line");
    a_master_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state == SMSP_LEAD) |-> ##[1:64] (state != SMSP_LEAD))
        else $error("master start too late");
    a_tx_irq_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_data |=> !ctl[SMSP_CTL_TX_IRQ_EN])
        else $error("data write left tx irq enable set");
    a_idle_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state == SMSP_IDLE && $past(state) == SMSP_IDLE) |-> sclk_o == clock_polarity)
        else $error("clock idle level wrong");
    a_overrun_keep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        stat[SMSP_ST_OVERRUN] |=> $stable(rx_data))
        else $error("byte captured during overrun");
    a_role_drive: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !ctl[SMSP_CTL_MASTER] |-> !sclk_oe_o && !mosi_oe_o)
        else $error("slave drives clock or out line");
endmodule : smsp_port // smsp_port
`default_nettype wire

/* testbench/smsp_remote.sv */
/* smsp_remote: far-side slave for the port in master mode.
   Assumes clock mode 0 and a select that is always active. */
`timescale 1ns/1ps
`default_nettype none
module smsp_remote (
    input  wire logic       sclk_i, // serial clock from the port
    input  wire logic       mosi_i, // data from the port
    input  wire logic       arm_i,  // rising edge loads load_i
    input  wire logic [7:0] load_i, // byte to send
    output logic            miso_o, // data to the port
    output logic [7:0]      got_o   // byte received
);
    logic [7:0] tx;
    // msb stands before the first edge, as phase 0 needs
    assign miso_o = tx[7];
    // sample on the leading edge
    always @(posedge sclk_i) got_o <= {got_o[6:0], mosi_i};
    // shift on the trailing edge; zeros fill behind
    always @(posedge arm_i or negedge sclk_i)
        if (arm_i) tx <= load_i;
        else tx <= {tx[6:0], 1'b0};
endmodule // smsp_remote
`default_nettype wire

/* testbench/spi_master_slave_port_bench.sv */
/* spi_master_slave_port_bench: self-checking bench for smsp_port.
   Assumes smsp_remote on the far side; the bench plays remote master. */
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port_bench;
    import smsp_pkg::*;
    logic        clk_i, reset_n_i, select_n_i, b_sclk, b_mosi, r_miso, arm;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, sclk_o, sclk_oe_o, mosi_o;
    logic        mosi_oe_o, miso_o, miso_oe_o;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, load, got;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    int          n_mismatch, comparisons;
    // a line carries whoever enables onto it
    wire logic sclk_w = sclk_oe_o ? sclk_o : b_sclk;
    wire logic mosi_w = mosi_oe_o ? mosi_o : b_mosi;
    wire logic miso_w = miso_oe_o ? miso_o : r_miso;
    smsp_port i_smsp_port (.*, .sclk_i(sclk_w), .mosi_i(mosi_w), .miso_i(miso_w));
    smsp_remote i_smsp_remote (.sclk_i(sclk_w), .mosi_i(mosi_w), .arm_i(arm),
                               .load_i(load), .miso_o(r_miso), .got_o(got));
    // bus clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task tmo(input string nm);
        chk(nm, 32'h1, 32'h0);
        final_report;
    endtask
    // one register access; each channel is held until its own ready
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic ta, tw, tr, td;
        @(posedge clk_i);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        for (n = 0; n < 50; n++) begin
            #1;
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tr = s_axi_arvalid & s_axi_arready;
            td = w ? s_axi_bvalid : s_axi_rvalid;
            {rr, rv} = {w ? s_axi_bresp : s_axi_rresp, s_axi_rdata};
            @(posedge clk_i);
            s_axi_awvalid <= s_axi_awvalid & !ta;
            s_axi_wvalid <= s_axi_wvalid & !tw;
            s_axi_arvalid <= s_axi_arvalid & !tr;
            if (td) break;
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
        if (n == 50) tmo("bus");
    endtask
    // status polling; a stale value must not end the wait early
    task wait_flag(input int b);
        int n;
        rv = 32'h0;
        for (n = 0; n < 500 && rv[b] !== 1'b1; n++) bus(1'b0, SMSP_ADDR_STATUS, 32'h0);
        if (n == 500) tmo("flag");
    endtask
    task t_reset;
        bus(1'b0, SMSP_ADDR_CONTROL, 32'h0);
        chk("control", 32'h28, rv);
        bus(1'b0, SMSP_ADDR_STATUS, 32'h0);
        chk("status", 32'h08, rv);
        bus(1'b0, 8'h4c, 32'h0);
        chk("unmapped", {30'h0, SMSP_RESP_SLVERR}, {30'h0, rr});
        chk("enables", 32'h0, {29'h0, sclk_oe_o, mosi_oe_o, miso_oe_o});
    endtask
    // master byte at rate r while the remote answers rx
    task t_master(input int r, input logic [7:0] tx, input logic [7:0] rx);
        int n;
        int h;
        load <= rx;
        arm <= 1'b1;
        bus(1'b1, SMSP_ADDR_STATUS, 32'(r));
        arm <= 1'b0;
        bus(1'b1, SMSP_ADDR_CONTROL, 32'h23);
        bus(1'b1, SMSP_ADDR_DATA, {24'h0, tx});
        #1;
        for (n = 0; n < 400 && sclk_o !== 1'b1; n++) @(posedge clk_i) #1;
        chk("start", 32'h1, {31'h0, n <= (3 << (2 * r))});
        for (h = 0; h < 400 && sclk_o === 1'b1; h++) @(posedge clk_i) #1;
        chk("high time", 32'(1 << (2 * r)), 32'(h));
        wait_flag(SMSP_ST_RX_FULL);
        chk("tx empty", 32'h1, {31'h0, rv[SMSP_ST_TX_EMPTY]});
        bus(1'b0, SMSP_ADDR_DATA, 32'h0);
        chk("rx byte", {24'h0, rx}, rv);
        chk("sent byte", {24'h0, tx}, {24'h0, got});
        bus(1'b0, SMSP_ADDR_STATUS, 32'h0);
        chk("rx full", 32'h0, {31'h0, rv[SMSP_ST_RX_FULL]});
        bus(1'b0, SMSP_ADDR_CONTROL, 32'h0);
        chk("control", 32'h22, rv);
    endtask
    // second byte lands while the first is unread: flag up, first byte kept
    task t_overrun;
        load <= 8'h81;
        arm <= 1'b1;
        bus(1'b1, SMSP_ADDR_STATUS, 32'h0);
        arm <= 1'b0;
        bus(1'b1, SMSP_ADDR_DATA, 32'h11);
        wait_flag(SMSP_ST_RX_FULL);
        bus(1'b1, SMSP_ADDR_DATA, 32'h22);
        repeat (40) @(posedge clk_i);
        wait_flag(SMSP_ST_OVERRUN);
        bus(1'b0, SMSP_ADDR_DATA, 32'h0);
        chk("kept byte", 32'h81, rv);
        bus(1'b0, SMSP_ADDR_STATUS, 32'h0);
        chk("flags clear", 32'h08, rv);
    endtask
    // slave byte in control mode m; the bench clocks rx in and watches tx
    task t_slave(input logic [7:0] m, input logic [7:0] tx, input logic [7:0] rx);
        int   i;
        logic p, c;
        p = m[SMSP_CTL_CLOCK_POLARITY];
        c = m[SMSP_CTL_CLOCK_PHASE];
        bus(1'b1, SMSP_ADDR_CONTROL, 32'h00);
        b_sclk <= p;
        bus(1'b1, SMSP_ADDR_CONTROL, {24'h0, m});
        bus(1'b1, SMSP_ADDR_DATA, {24'h0, tx});
        chk("unselected", 32'h0, {31'h0, miso_oe_o});
        select_n_i <= 1'b0;
        for (i = 7; i >= 0; i--) begin
            repeat (4) @(posedge clk_i);
            b_sclk <= p ^ c;
            b_mosi <= rx[i];
            repeat (4) @(posedge clk_i);
            chk("miso", {30'h0, 1'b1, tx[i]}, {30'h0, miso_oe_o, miso_w});
            b_sclk <= ~(p ^ c);
        end
        repeat (4) @(posedge clk_i);
        b_sclk <= p;
        repeat (4) @(posedge clk_i);
        select_n_i <= 1'b1;
        b_mosi <= ~rx[0];
        wait_flag(SMSP_ST_RX_FULL);
        bus(1'b0, SMSP_ADDR_DATA, 32'h0);
        chk("slave rx", {24'h0, rx}, rv);
    endtask
    // reset for three cycles, then the scenarios in turn
    initial begin
        {reset_n_i, b_sclk, b_mosi, arm, load, rv, rr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {select_n_i, s_axi_wstrb} = 5'h1f;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset;
        for (int r = 0; r < 4; r++) t_master(r, 8'ha5 ^ 8'(r), 8'h3c + 8'(r));
        t_overrun;
        t_slave(8'h0a, 8'h96, 8'h6d);
        t_slave(8'h12, 8'h5a, 8'hc3);
        final_report;
    end
endmodule // spi_master_slave_port_bench
`default_nettype wire
